// file: hw/pdc_pkg.sv
// Package for the performance-state domain coordinator: widths, modes, query types.
// Assumes a single system clock; all users reference items as pdc_pkg::name.
package pdc_pkg;
    localparam int PSTATE_W   = 4;
    localparam int PERF_W     = 8;
    localparam int ACC_W      = 24;
    localparam int CNT_W      = 16;
    localparam int QTYPE_W    = 2;
    // Reset values
    localparam logic [PSTATE_W-1:0] PSTATE_RESET = 4'h0;
    // Query type selectors
    localparam logic [QTYPE_W-1:0] QTYPE_RECENT  = 2'h0;
    localparam logic [QTYPE_W-1:0] QTYPE_AVG_RST = 2'h1;
    localparam logic [QTYPE_W-1:0] QTYPE_AVG     = 2'h2;
    localparam logic [QTYPE_W-1:0] QTYPE_DOMAIN  = 2'h3;
    // Domain coordination mode
    typedef enum logic [2:0] {
        PDC_MODE_SW    = 3'h1,
        PDC_MODE_HW    = 3'h2,
        PDC_MODE_INDEP = 3'h4
    } pdc_mode_t;
endpackage

// file: hw/pdc_coordinator.sv
// Performance-state domain coordinator: per-core requests, domain level, power-cap, index.
// Assumes requests, cap and queries come from logic on mclk_i; mode is a level strap.
//
// Summary of operation
// - In hardware coordination the domain level is the smallest requested state number.
// - Each core requests its state on its own port and the block does the coordination.
// - A core asking for a slower state than the domain gets it through local settings only.
// - When all cores slow down, the domain moves to the fastest request and that core's local offset clears.
// - In software coordination a request sets every core to the same new state at once.
// - A power-cap never alters the recorded per-core requests.
// - Requests are accepted and recorded while a cap is active.
// - When the cap goes away the operating level returns to the coordinated domain level.
// - The reported current state ignores the cap, the averaged index includes it.
// - A query of type 1 restarts the index accumulation, reported at the next query.
`timescale 1ns/1ps
`default_nettype none
module pdc_coordinator #(
    parameter int NCORE = 2
) (
    // Clock, reset, enable
    input  wire logic                                  mclk_i,
    input  wire logic                                  reset_i,
    input  wire logic                                  clk_en_i,
    // Domain mode
    input  wire pdc_pkg::pdc_mode_t                    mode_i,
    // Core requests
    input  wire logic [NCORE-1:0]                      req_valid_i,
    input  wire logic [NCORE*pdc_pkg::PSTATE_W-1:0]    req_state_i,
    // Platform power-cap
    input  wire logic                                  cap_active_i,
    input  wire logic [pdc_pkg::PSTATE_W-1:0]          cap_state_i,
    // Performance query
    input  wire logic                                  query_perf_state_i,
    input  wire logic [$clog2(NCORE>1?NCORE:2)-1:0]    query_core_i,
    input  wire logic [pdc_pkg::QTYPE_W-1:0]           query_type_i,
    // Levels
    output logic [pdc_pkg::PSTATE_W-1:0]               domain_state_o,
    output logic [pdc_pkg::PSTATE_W-1:0]               eff_state_o,
    output logic [NCORE*pdc_pkg::PSTATE_W-1:0]         local_state_o,
    output logic [NCORE-1:0]                           local_active_o,
    // Query answer
    output logic                                       query_valid_o,
    output logic [pdc_pkg::ACC_W-1:0]                  query_data_o
);
    localparam int PW = pdc_pkg::PSTATE_W;
    localparam int AW = pdc_pkg::ACC_W;

    typedef struct packed {
        logic [NCORE-1:0][PW-1:0] req;
        logic [PW-1:0]            domain;
        logic [PW-1:0]            eff;
        logic [NCORE-1:0][PW-1:0] loc;
        logic [NCORE-1:0]         loc_act;
        logic [AW-1:0]            acc;
        logic [pdc_pkg::CNT_W-1:0] cnt;
        logic                     qv;
        logic [AW-1:0]            qd;
    } pdc_state_t;

    pdc_state_t r;
    pdc_state_t next_r;

    // Slower of two state numbers (larger number means lower performance)
    function automatic logic [PW-1:0] pdc_slower(input logic [PW-1:0] a, input logic [PW-1:0] b);
        pdc_slower = (a > b) ? a : b;
    endfunction

    // Smallest state number over all requests
    function automatic logic [PW-1:0] pdc_fastest(input logic [NCORE-1:0][PW-1:0] v);
        logic [PW-1:0] m;
        m = v[0];
        for (int k = 1; k < NCORE; k++)
        begin
            if (v[k] < m)
                m = v[k];
        end
        pdc_fastest = m;
    endfunction

    // Next-state computation
    always_comb
    begin
        logic [NCORE-1:0][PW-1:0] nreq;
        logic [PW-1:0]            ndom;
        logic                     sel;
        next_r = r;
        nreq   = r.req;
        sel    = 1'b0;
        ndom   = r.domain;
        // Record requests regardless of the cap
        for (int c = 0; c < NCORE; c++)
        begin
            if (req_valid_i[c])
            begin
                nreq[c] = req_state_i[c*PW +: PW];
                sel = 1'b1;
            end
        end
        if (mode_i == pdc_pkg::PDC_MODE_SW && sel)
        begin
            for (int c = 0; c < NCORE; c++)
            begin
                if (req_valid_i[c])
                    ndom = req_state_i[c*PW +: PW];
            end
            for (int c = 0; c < NCORE; c++)
                nreq[c] = ndom;
        end
        ndom = pdc_fastest(nreq);
        next_r.req    = nreq;
        next_r.domain = ndom;
        // Local settings carry any request slower than the domain
        for (int c = 0; c < NCORE; c++)
        begin
            next_r.loc_act[c] = (nreq[c] != ndom);
            next_r.loc[c]     = (nreq[c] != ndom) ? nreq[c] : ndom;
        end
        // Cap applied on top of the coordinated level
        next_r.eff = cap_active_i ? pdc_slower(r.domain, cap_state_i) : r.domain;
        // Accumulate the operating level including the cap
        next_r.acc = r.acc + AW'(r.eff);
        next_r.cnt = r.cnt + 1'b1;
        next_r.qv  = 1'b0;
        if (query_perf_state_i)
        begin
            next_r.qv = 1'b1;
            unique case (query_type_i)
                pdc_pkg::QTYPE_RECENT: next_r.qd = AW'(r.req[query_core_i]);
                pdc_pkg::QTYPE_DOMAIN: next_r.qd = AW'(r.domain);
                default:               next_r.qd = r.acc;
            endcase
            if (query_type_i == pdc_pkg::QTYPE_AVG_RST)
            begin
                next_r.acc = '0;
                next_r.cnt = '0;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            r <= '0;
        end
        else if (clk_en_i)
        begin
            r <= next_r;
        end
    end

    // Outputs
    assign domain_state_o = r.domain;
    assign eff_state_o    = r.eff;
    assign local_state_o  = r.loc;
    assign local_active_o = r.loc_act;
    assign query_valid_o  = r.qv;
    assign query_data_o   = r.qd;

    // Domain never slower than any request in hardware coordination
    a_domain_is_min: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && $past(clk_en_i) && mode_i == pdc_pkg::PDC_MODE_HW)
        |-> (r.domain == pdc_fastest(r.req)))
        else $error("domain level not fastest request");
    // Local flag follows whether a request differs from the domain
    a_local_flag_ok: assert property (@(posedge mclk_i) disable iff (reset_i)
        (local_active_o[0] == (r.req[0] != r.domain)))
        else $error("local flag wrong for core 0");
    a_eff_cap_slower: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && cap_active_i) |=> (eff_state_o >= $past(r.domain)))
        else $error("effective level faster than domain under cap");
    a_cap_release_back: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && !cap_active_i) |=> (eff_state_o == $past(r.domain)))
        else $error("effective level not restored after cap");
    // Requests survive a cap untouched when nobody asks for a change
    a_cap_keeps_req: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && cap_active_i && req_valid_i == '0 && mode_i == pdc_pkg::PDC_MODE_HW)
        |=> (r.req == $past(r.req)))
        else $error("cap altered a request");
    a_req_recorded: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && req_valid_i[0] && mode_i == pdc_pkg::PDC_MODE_HW)
        |=> (r.req[0] == $past(req_state_i[PW-1:0])))
        else $error("request not recorded");
    a_sw_all_same: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && req_valid_i != '0 && mode_i == pdc_pkg::PDC_MODE_SW)
        |=> (r.req[NCORE-1] == r.req[0] && local_active_o == '0))
        else $error("software domain cores differ");
    a_query_resets: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && query_perf_state_i && query_type_i == pdc_pkg::QTYPE_AVG_RST)
        |=> (r.acc == '0 && query_valid_o))
        else $error("type 1 query did not restart index");
    // The reported domain level moves only on a request, never on the cap
    a_domain_ignores_cap: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && req_valid_i == '0)
        |=> (domain_state_o == $past(domain_state_o)))
        else $error("domain level moved without a request");
    // A local setting is always slower than the domain it sits under
    a_local_is_slower: assert property (@(posedge mclk_i) disable iff (reset_i)
        local_active_o[NCORE-1] |-> (local_state_o[(NCORE-1)*PW +: PW] > domain_state_o))
        else $error("local setting not slower than domain");
    // The core holding the fastest request runs on domain settings alone
    a_fastest_no_local: assert property (@(posedge mclk_i) disable iff (reset_i)
        (r.req[0] == domain_state_o)
        |-> (!local_active_o[0] && local_state_o[PW-1:0] == domain_state_o))
        else $error("fastest core still on local settings");
    // The query answer strobe clears on the first enabled cycle after a cycle without a query
    a_query_one_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && !query_perf_state_i) |=> !query_valid_o)
        else $error("query answer held longer than one cycle");
    // Under a cap the operating level is exactly the slower of the two
    a_eff_exact_cap: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && cap_active_i)
        |=> (eff_state_o == pdc_slower($past(r.domain), $past(cap_state_i))))
        else $error("effective level not the slower of domain and cap");
    // The last core's request lands in its own slot
    a_req_any_core: assert property (@(posedge mclk_i) disable iff (reset_i)
        (clk_en_i && req_valid_i[NCORE-1] && mode_i != pdc_pkg::PDC_MODE_SW)
        |=> (r.req[NCORE-1] == $past(req_state_i[(NCORE-1)*PW +: PW])))
        else $error("last core request not recorded");
endmodule
`default_nettype wire

// file: verification/pdc_core_model.sv
// Requesting cores: one strobe per request, state lines scrambled when idle.
// Assumes the bench calls issue() from its own thread on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module pdc_core_model (
    // Clock
    input  wire logic        mclk_i,
    // Requests to the block
    output logic [1:0]       req_valid_o,
    output logic [7:0]       req_state_o
);
    // Idle at time zero
    initial
    begin
        req_valid_o = '0;
        req_state_o = '0;
    end
    // Each core asks on its own lane; coordination is the block's job
    task automatic issue(input int c, input logic [3:0] s);
        @(posedge mclk_i);
        #1;
        req_state_o[c*4 +: 4] = s;
        req_valid_o[c] = 1'b1;
        @(posedge mclk_i);
        #1;
        req_valid_o = '0;
        req_state_o = ~req_state_o; // Stale state is not held
    endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the domain coordinator.
// Assumes the core model drives requests; the bench drives cap, mode and queries.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic               mclk_i;
    logic               reset_i;
    logic               en;
    pdc_pkg::pdc_mode_t mode;
    logic [1:0]         rv;
    logic [7:0]         rs;
    logic               cap;
    logic [3:0]         caps;
    logic               qi;
    logic [0:0]         qc;
    logic [1:0]         qt;
    logic [3:0]         dom;
    logic [3:0]         eff;
    logic [7:0]         loc;
    logic [1:0]         act;
    logic               qv;
    logic [23:0]        qd;
    logic [23:0]        a;
    logic [23:0]        b;
    int                 miscompares = 0;
    int                 num_checks = 0;
    int                 cyc = 0;
    pdc_core_model cores (.mclk_i(mclk_i), .req_valid_o(rv), .req_state_o(rs));
    pdc_coordinator uut (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(en), .mode_i(mode),
        .req_valid_i(rv), .req_state_i(rs), .cap_active_i(cap), .cap_state_i(caps),
        .query_perf_state_i(qi), .query_core_i(qc), .query_type_i(qt),
        .domain_state_o(dom), .eff_state_o(eff), .local_state_o(loc),
        .local_active_o(act), .query_valid_o(qv), .query_data_o(qd));
    // Clock
    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic query(input logic [1:0] t, input logic c, output logic [23:0] d);
        w(1);
        qi = 1'b1;
        qt = t;
        qc = c;
        w(1);
        qi = 1'b0;
        for (int i = 0; i < 4 && qv !== 1'b1; i++)
            w(1);
        check("qv", qv, 1'b1);
        d = qd;
    endtask
    // Reset held n cycles: outputs read zero while held and just after release
    task automatic scn_reset(input int n);
        reset_i = 1'b1;
        w(n);
        check("reset", {dom, eff, loc, act, qv}, 24'h0);
        check("reset_qd", qd, 24'h0);
        reset_i = 1'b0;
        w(1);
        check("released", {dom, eff, loc, act, qv}, 24'h0);
    endtask
    // Hardware coordination: slower core goes local, then the domain moves
    task automatic scn_hw();
        cores.issue(0, 4'h1);
        w(3);
        check("dom0", {dom, act, loc[3:0]}, {4'h0, 2'h1, 4'h1});
        cores.issue(1, 4'h3);
        w(3);
        check("dom1", {dom, act, loc[7:4], eff}, {4'h1, 2'h2, 4'h3, 4'h1});
        check("loc0", loc[3:0], 24'h1);
        query(pdc_pkg::QTYPE_RECENT, 1'b1, a);
        check("qrec1", a, 24'h3);
    endtask
    // Power-cap slows the operating level only; requests land and come back
    task automatic scn_cap();
        cap = 1'b1;
        caps = 4'h5;
        w(3);
        check("capeff", {eff, dom}, 24'h51);
        query(pdc_pkg::QTYPE_DOMAIN, 1'b0, a);
        check("qdom", a, 24'h1);
        cores.issue(0, 4'h2);
        w(3);
        query(pdc_pkg::QTYPE_RECENT, 1'b0, a);
        check("qrec", {a[3:0], eff}, 24'h25);
        cap = 1'b0;
        w(3);
        check("uncap", eff, 24'h2);
    endtask
    // Software coordination: one request moves every core together
    task automatic scn_sw();
        mode = pdc_pkg::PDC_MODE_SW;
        cores.issue(1, 4'h4);
        w(3);
        check("sw", {dom, loc, act}, {4'h4, 8'h44, 2'h0});
        mode = pdc_pkg::PDC_MODE_HW;
    endtask
    // Clock enable low: a request and a query are both ignored
    task automatic scn_freeze();
        en = 1'b0;
        cores.issue(0, 4'h1);
        qi = 1'b1;
        w(1);
        qi = 1'b0;
        w(1);
        check("frozen", {dom, act, qv}, {4'h4, 2'h0, 1'h0});
        en = 1'b1;
        query(pdc_pkg::QTYPE_RECENT, 1'b0, a);
        check("frozenreq", a, 24'h4);
    endtask
    // Averaged index: a type 1 query restarts the sum, the next one reports it
    task automatic scn_index();
        w(40);
        query(pdc_pkg::QTYPE_AVG, 1'b0, a);
        query(pdc_pkg::QTYPE_AVG_RST, 1'b0, b);
        query(pdc_pkg::QTYPE_AVG, 1'b0, b);
        check("avgrst", b < a, 24'h1);
        check("avgsum", b, 24'h4);
    endtask
    // Reset in mid-run, then a request straight after release
    task automatic scn_midreset();
        scn_reset(3);
        cores.issue(0, 4'h2);
        check("postrst", {dom, act, loc[3:0]}, {4'h0, 2'h1, 4'h2});
    endtask
    // Main sequence
    initial
    begin
        en = 1'b1;
        mode = pdc_pkg::PDC_MODE_HW;
        cap = 1'b0;
        caps = 4'h0;
        qi = 1'b0;
        qc = 1'b0;
        qt = 2'h0;
        scn_reset(12);
        scn_hw();
        scn_cap();
        scn_sw();
        scn_freeze();
        scn_index();
        scn_midreset();
        print_verdict();
    end
endmodule
`default_nettype wire
